//--- port_reset_pkg.sv
// Purpose: Shared constants for the port reset and pin-state block.
// Assumes: 100 MHz aclk, AXI4-Lite register access with 8-bit addresses.
// Notes:   Register fields sit in the low byte of each 32-bit word.
package port_reset_pkg;
    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int STROBE_W = 3;
    localparam int PORT_C = 2;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    // Usable bits of each port; the last port has five
    localparam logic [7:0] WIDE_MASK = 8'hFF;
    localparam logic [7:0] NARROW_MASK = 8'h1F;
    // Test access pins on the sixth port: clock 4, mode 5, out 6, in 7
    localparam int TDO_BIT = 6;
    localparam logic [7:0] JTAG_MASK = 8'hF0;
    localparam logic [7:0] JTAG_PU_MASK = 8'hB0;
    // Strobe bits 0..2 and their forced reset levels (1, 1, 0)
    localparam logic [7:0] STROBE_MASK = 8'h07;
    localparam logic [7:0] STROBE_RST_VAL = 8'h03;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OUT_BASE = 8'h00;
    localparam logic [7:0] DIR_BASE = 8'h20;
    localparam logic [7:0] PUE_BASE = 8'h40;
    localparam logic [7:0] PIN_BASE = 8'h60;
    localparam logic [7:0] STATUS_ADDR = 8'h80;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Reset values of mode inputs before the first samples
    // ------------------------------------------------------------
    localparam logic FUSE_RESET = 1'b1;
    localparam logic ENTRY_RESET = 1'b1;
    localparam logic [1:0] POR_SAMPLE_CNT = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_MIN_PULSE_NS = 1000;
    localparam int RST_MIN_PULSE_CYC =
        (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- pad_ctrl_if.sv
// Purpose: Carries the control of one port's pads from logic to cell.
// Assumes: All vectors are one port wide.
// Notes:   rst_* fields apply only while a reset holds the pins.
interface pad_ctrl_if;
    logic [7:0] out_val;
    logic [7:0] dir;
    logic [7:0] pu_req;
    logic [7:0] rst_oe;
    logic [7:0] rst_val;
    logic [7:0] rst_pu;
    logic in_rst;
    modport ctrl (
        output out_val, dir, pu_req, rst_oe, rst_val, rst_pu, in_rst
    );
    modport pad (
        input out_val, dir, pu_req, rst_oe, rst_val, rst_pu, in_rst
    );
endinterface

//--- port_pad_cell.sv
// Purpose: Pad drive, enable and pull-up selection for one port.
// Assumes: in_rst comes straight from the reset pins, no clock needed.
// Notes:   Purely combinational so reset acts with the clock stopped.
module port_pad_cell (
    // Control from the port logic
    pad_ctrl_if.pad ctl,
    // Pad side
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pu
);
    // ------------------------------------------------------------
    // Reset override
    // ------------------------------------------------------------
    // Reset swaps in the fixed pattern without waiting for an edge
    assign pad_oe = ctl.in_rst ? ctl.rst_oe : ctl.dir;
    assign pad_out = ctl.in_rst ? ctl.rst_val : ctl.out_val;
    // Pull-up never fights a driven pin
    assign pad_pu = ctl.in_rst ? ctl.rst_pu : (ctl.pu_req & ~ctl.dir);
endmodule

//--- port_reset_pin_state.sv
// Purpose: Register control and reset-time pin state for seven ports.
// Assumes: Pins and mode straps are asynchronous and get synchronised.
// Notes:   Pin reset and aresetn both float pins with no clock edge.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.

// Overview of operation
// - Six eight-bit ports, each bit own direction.
// - Seventh port has five bits, zero to four.
// - Every bit has its own pull-up enable.
// - Reset floats all pins without a clock.
// - Legacy mode: third port outputs, drives during reset.
// - Legacy mode is the power-up default.
// - Sixth port shared between converter and plain I/O.
// - Test pins keep pull-ups during reset.
// - Test data out floats unless shifting.
// - Legacy mode: sixth port input only.
// - Legacy mode: strobes reset to 1,1,0 asynchronously.
// - Legacy mode: strobes plus oscillator bits three, four.
// - Reset pin needs minimum low pulse length.
// - Programming entry pin low at power-on reset.
// - Legacy mode read from a static fuse.
// - Legacy mode: seventh port alternate functions only.
module port_reset_pin_state #(
    parameter int MIN_PULSE_CYC = port_reset_pkg::RST_MIN_PULSE_CYC
) (
    // Clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External reset pin
    input wire logic reset_pin_n,
    // Port pads
    input wire logic [6:0][7:0] port_in,
    output logic [6:0][7:0] port_out,
    output logic [6:0][7:0] port_oe,
    output logic [6:0][7:0] port_pu,
    // Mode straps and sideband
    input wire logic legacy_compat_fuse,
    input wire logic jtag_enable,
    input wire logic [7:0] adc_in_use,
    input wire logic tap_shift_out,
    input wire logic tap_tdo,
    input wire logic [2:0] mem_strobe,
    input wire logic serial_prog_entry_pin,
    output logic serial_prog_mode
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Returns {hit, port index} for a per-port register bank
    function automatic logic [3:0] bank_sel(
        input logic [7:0] addr,
        input logic [7:0] base
    );
        logic hit;
        hit = (addr[7:5] == base[7:5]) && (addr[1:0] == 2'h0)
            && (addr[4:2] < 3'(port_reset_pkg::NUM_PORTS));
        bank_sel = {hit, addr[4:2]};
    endfunction

    // Bits of a port that exist, so missing bits read zero
    function automatic logic [7:0] port_mask(input int p);
        port_mask = (p == port_reset_pkg::PORT_G) ?
            port_reset_pkg::NARROW_MASK : port_reset_pkg::WIDE_MASK;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int PIN_BITS = 56;
    localparam int SYNC_W = PIN_BITS + 17;
    // Fuse resets to legacy and entry pin to its pulled-high level
    localparam logic [SYNC_W-1:0] SYNC_INIT = {
        {PIN_BITS{1'b0}},
        1'b1,
        port_reset_pkg::FUSE_RESET,
        1'b0,
        8'h00,
        1'b0,
        1'b0,
        3'h0,
        port_reset_pkg::ENTRY_RESET
    };

    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_a_r;
    logic [SYNC_W-1:0] sync_b_r;

    assign sync_raw = {
        port_in,
        reset_pin_n,
        legacy_compat_fuse,
        jtag_enable,
        adc_in_use,
        tap_shift_out,
        tap_tdo,
        mem_strobe,
        serial_prog_entry_pin
    };

    // Two stages; only the second stage feeds logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_r <= SYNC_INIT;
            sync_b_r <= SYNC_INIT;
        end else begin
            sync_a_r <= sync_raw;
            sync_b_r <= sync_a_r;
        end
    end

    // Named views of the synchronised bundle
    logic [6:0][7:0] pin_s;
    logic rst_pin_s;
    logic legacy;
    logic jtag_s;
    logic [7:0] adc_s;
    logic shift_s;
    logic tdo_s;
    logic [2:0] strobe_s;
    logic entry_s;

    assign {pin_s, rst_pin_s, legacy, jtag_s, adc_s, shift_s,
            tdo_s, strobe_s, entry_s} = sync_b_r;

    // ------------------------------------------------------------
    // Reset pin pulse filter
    // ------------------------------------------------------------
    // Glitches shorter than the minimum do not clear registers
    localparam int CNT_W = $clog2(MIN_PULSE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MIN_PULSE_CYC - 1);

    logic [CNT_W-1:0] low_cnt_r;
    logic [CNT_W-1:0] low_cnt_nxt;
    logic pin_rst_r;
    logic pin_rst_nxt;
    logic regs_rst;

    assign low_cnt_nxt = rst_pin_s ? '0 :
        (low_cnt_r == CNT_LAST) ? low_cnt_r : low_cnt_r + CNT_W'(1);
    assign pin_rst_nxt = !rst_pin_s && (low_cnt_r == CNT_LAST);
    assign regs_rst = !aresetn || pin_rst_r;

    // Counter of consecutive low samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_cnt_r <= '0;
            pin_rst_r <= 1'b0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
            pin_rst_r <= pin_rst_nxt;
        end
    end

    // ------------------------------------------------------------
    // Programming entry capture
    // ------------------------------------------------------------
    // Waits out the synchroniser before taking the entry pin
    logic [1:0] por_cnt_r;
    logic prog_mode_r;
    logic por_sample;

    assign por_sample = (por_cnt_r == port_reset_pkg::POR_SAMPLE_CNT);

    // Only a power-on reset samples; later the pin is ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_cnt_r <= 2'h0;
            prog_mode_r <= 1'b0;
        end else begin
            if (por_cnt_r != 2'h3) begin
                por_cnt_r <= por_cnt_r + 2'h1;
            end
            if (por_sample) begin
                prog_mode_r <= !entry_s;
            end
        end
    end

    assign serial_prog_mode = prog_mode_r;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // Address and data are taken together; waiting is the ordering
    logic wr_go;
    logic [3:0] wr_out;
    logic [3:0] wr_dir;
    logic [3:0] wr_pue;
    logic wr_hit;
    logic bvalid_r;
    logic [1:0] bresp_r;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign wr_out = bank_sel(s_axi_awaddr, port_reset_pkg::OUT_BASE);
    assign wr_dir = bank_sel(s_axi_awaddr, port_reset_pkg::DIR_BASE);
    assign wr_pue = bank_sel(s_axi_awaddr, port_reset_pkg::PUE_BASE);
    assign wr_hit = wr_out[3] || wr_dir[3] || wr_pue[3];

    // Response follows one cycle after both channels are taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= port_reset_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? port_reset_pkg::RESP_OKAY :
                port_reset_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ------------------------------------------------------------
    // Port control registers
    // ------------------------------------------------------------
    logic [6:0][7:0] out_r;
    logic [6:0][7:0] dir_r;
    logic [6:0][7:0] pue_r;
    logic wr_lane;

    // Fields live in byte lane 0 only
    assign wr_lane = wr_go && s_axi_wstrb[0];

    for (genvar p = 0; p < port_reset_pkg::NUM_PORTS; p++) begin : g_regs
        logic sel_out;
        logic sel_dir;
        logic sel_pue;
        logic [7:0] wbyte;

        assign sel_out = wr_lane && wr_out[3] && (wr_out[2:0] == 3'(p));
        assign sel_dir = wr_lane && wr_dir[3] && (wr_dir[2:0] == 3'(p));
        assign sel_pue = wr_lane && wr_pue[3] && (wr_pue[2:0] == 3'(p));
        assign wbyte = s_axi_wdata[7:0] & port_mask(p);

        // Each bit keeps its own direction and pull-up
        always_ff @(posedge aclk) begin
            if (regs_rst) begin
                out_r[p] <= port_reset_pkg::REG_RESET;
                dir_r[p] <= port_reset_pkg::REG_RESET;
                pue_r[p] <= port_reset_pkg::REG_RESET;
            end else begin
                if (sel_out) begin
                    out_r[p] <= wbyte;
                end
                if (sel_dir) begin
                    dir_r[p] <= wbyte;
                end
                if (sel_pue) begin
                    pue_r[p] <= wbyte;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [3:0] rd_out;
    logic [3:0] rd_dir;
    logic [3:0] rd_pue;
    logic [3:0] rd_pin;
    logic rd_stat;
    logic rd_go;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [7:0] status_byte;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = rd_go;
    assign rd_out = bank_sel(s_axi_araddr, port_reset_pkg::OUT_BASE);
    assign rd_dir = bank_sel(s_axi_araddr, port_reset_pkg::DIR_BASE);
    assign rd_pue = bank_sel(s_axi_araddr, port_reset_pkg::PUE_BASE);
    assign rd_pin = bank_sel(s_axi_araddr, port_reset_pkg::PIN_BASE);
    assign rd_stat = (s_axi_araddr == port_reset_pkg::STATUS_ADDR);
    assign rd_hit = rd_out[3] || rd_dir[3] || rd_pue[3] || rd_pin[3]
        || rd_stat;

    // Mode summary so software can see why pins are overridden
    assign status_byte = {4'h0, pin_rst_r, prog_mode_r, jtag_s, legacy};

    // Pin readback masks off bits the port does not have
    assign rd_byte =
        rd_out[3] ? out_r[rd_out[2:0]] :
        rd_dir[3] ? dir_r[rd_dir[2:0]] :
        rd_pue[3] ? pue_r[rd_pue[2:0]] :
        rd_pin[3] ? pin_s[rd_pin[2:0]] & port_mask(int'(rd_pin[2:0])) :
        rd_stat ? status_byte : 8'h00;

    // Read data registered one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= port_reset_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? port_reset_pkg::RESP_OKAY :
                port_reset_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ------------------------------------------------------------
    // Pin state per port
    // ------------------------------------------------------------
    // Raw pins, not the filter, so pins float with the clock stopped
    logic in_rst;

    assign in_rst = !reset_pin_n || !aresetn;

    for (genvar p = 0; p < port_reset_pkg::NUM_PORTS; p++) begin : g_port
        pad_ctrl_if ctl ();

        assign ctl.in_rst = in_rst;

        if (p == port_reset_pkg::PORT_C) begin : g_c
            // Legacy mode: output only, keeps driving through reset
            assign ctl.dir = legacy ? 8'hFF : dir_r[p];
            assign ctl.out_val = out_r[p];
            assign ctl.pu_req = pue_r[p];
            assign ctl.rst_oe = legacy ? 8'hFF : 8'h00;
            assign ctl.rst_val = out_r[p];
            assign ctl.rst_pu = 8'h00;
        end else if (p == port_reset_pkg::PORT_F) begin : g_f
            logic [7:0] jt;
            logic [7:0] tdo_oe;
            logic [7:0] gp_dir;

            assign jt = jtag_s ? port_reset_pkg::JTAG_MASK : 8'h00;
            // Test data out drives only in shifting states
            assign tdo_oe = (jtag_s && shift_s) ?
                8'(1 << port_reset_pkg::TDO_BIT) : 8'h00;
            // Converter inputs give up the digital driver
            assign gp_dir = dir_r[p] & ~adc_s & ~jt;
            assign ctl.dir = legacy ? 8'h00 : (gp_dir | tdo_oe);
            assign ctl.out_val = (out_r[p] & ~jt)
                | (tdo_s ? tdo_oe : 8'h00);
            assign ctl.pu_req = (pue_r[p] & ~adc_s & ~jt)
                | (jtag_s ? port_reset_pkg::JTAG_PU_MASK : 8'h00);
            assign ctl.rst_oe = 8'h00;
            assign ctl.rst_val = 8'h00;
            // Test pull-ups survive reset
            assign ctl.rst_pu = jtag_s ?
                port_reset_pkg::JTAG_PU_MASK : 8'h00;
        end else if (p == port_reset_pkg::PORT_G) begin : g_g
            // Legacy mode: strobes out, oscillator bits left alone
            assign ctl.dir = legacy ? port_reset_pkg::STROBE_MASK :
                (dir_r[p] & port_reset_pkg::NARROW_MASK);
            assign ctl.out_val = legacy ? {5'h00, strobe_s} :
                (out_r[p] & port_reset_pkg::NARROW_MASK);
            assign ctl.pu_req = legacy ? 8'h00 :
                (pue_r[p] & port_reset_pkg::NARROW_MASK);
            // Strobes take 1,1,0 the moment reset arrives
            assign ctl.rst_oe = legacy ?
                port_reset_pkg::STROBE_MASK : 8'h00;
            assign ctl.rst_val = legacy ?
                port_reset_pkg::STROBE_RST_VAL : 8'h00;
            assign ctl.rst_pu = 8'h00;
        end else begin : g_plain
            // Ordinary port: software decides everything
            assign ctl.dir = dir_r[p];
            assign ctl.out_val = out_r[p];
            assign ctl.pu_req = pue_r[p];
            assign ctl.rst_oe = 8'h00;
            assign ctl.rst_val = 8'h00;
            assign ctl.rst_pu = 8'h00;
        end

        port_pad_cell u_pad (
            .ctl(ctl.pad),
            .pad_out(port_out[p]),
            .pad_oe(port_oe[p]),
            .pad_pu(port_pu[p])
        );
    end
endmodule

//--- port_pins_chk_sva.sv
// Purpose: Pin-state and bus checks on the port reset block.
// Assumes: Bound to the top module, sees only its ports.
// Notes:   Mode inputs count only after four cycles, past the synchroniser.
module port_pins_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Pins and straps
    input wire logic reset_pin_n,
    input wire logic [6:0][7:0] port_out,
    input wire logic [6:0][7:0] port_oe,
    input wire logic [6:0][7:0] port_pu,
    input wire logic legacy_compat_fuse,
    input wire logic jtag_enable,
    input wire logic tap_shift_out,
    input wire logic serial_prog_mode
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Plain port floats with pull-ups off while the pin reset holds
    float_pins_a: assert property (!reset_pin_n |->
        port_oe[0] == 8'h00 && port_pu[0] == 8'h00) else $error("pins driven in reset");
    legacy_hold_a: assert property (legacy_compat_fuse [*4] ##0 !reset_pin_n |->
        port_oe[2] == 8'hFF && port_oe[6] == 8'h07 && port_out[6][2:0] == 3'h3)
        else $error("legacy pins lost in reset");
    legacy_input_a: assert property (legacy_compat_fuse [*4] |-> port_oe[5] == 8'h00)
        else $error("sixth port driven in legacy mode");
    osc_bits_a: assert property (legacy_compat_fuse [*4] |-> port_oe[6][4:3] == 2'h0)
        else $error("oscillator bits driven");
    narrow_port_a: assert property (port_oe[6][7:5] == 3'h0 && port_pu[6][7:5] == 3'h0)
        else $error("missing bits of narrow port active");
    // Test pins keep pull-ups through a reset
    jtag_pull_a: assert property (jtag_enable [*4] ##0 !reset_pin_n |->
        port_pu[5] == port_reset_pkg::JTAG_PU_MASK) else $error("test pull-ups lost");
    tdo_float_a: assert property ((jtag_enable && !tap_shift_out) [*4] |-> !port_oe[5][6])
        else $error("test data out driven outside shift");
    pull_gate_a: assert property ((port_pu[0] & port_oe[0]) == 8'h00)
        else $error("pull-up on a driven bit");
    write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
        |=> s_axi_bvalid) else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    // Mode moves only at the capture after a power-on reset
    prog_latch_a: assert property ($changed(serial_prog_mode) |-> !$past(aresetn, 4))
        else $error("programming mode changed in run");
    cover property (legacy_compat_fuse && !reset_pin_n);
    cover property (jtag_enable && tap_shift_out && port_oe[5][6]);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind port_reset_pin_state port_pins_chk chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .reset_pin_n, .port_out, .port_oe, .port_pu, .legacy_compat_fuse, .jtag_enable,
    .tap_shift_out, .serial_prog_mode);

//--- board_model.sv
// Purpose: Board side of the port pads, resolving each pin level.
// Assumes: Nothing else on the board drives the pins.
// Notes:   A floating pin reads high with its pull-up on, else the inverse of its port_out value.
module board_model (
    // Pad control from the block
    input wire logic [6:0][7:0] port_out,
    input wire logic [6:0][7:0] port_oe,
    input wire logic [6:0][7:0] port_pu,
    // Pin levels back to the block
    output logic [6:0][7:0] port_in
);
    // Driver wins, then pull-up; a float flips so it never looks held
    assign port_in = (port_oe & port_out) | (~port_oe & (port_pu | ~port_out));
endmodule

//--- test_port_reset_pin_state.sv
// Purpose: Self-checking bench for the port reset block.
// Assumes: Pin filter shortened to three cycles.
// Notes:   Every wait is bounded; a hang ends in the verdict.
module test_port_reset_pin_state;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0, aresetn = 1'h0, reset_pin_n = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tap_shift_out = 1'h0, tap_tdo = 1'h1;
    logic legacy_compat_fuse = 1'h1, jtag_enable = 1'h0, serial_prog_entry_pin = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, adc_in_use = 8'h00, m;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] mem_strobe = 3'h5;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic serial_prog_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [6:0][7:0] port_in, port_out, port_oe, port_pu;
    int num_errors = 0, comparisons = 0, n;

    always #5 aclk = ~aclk;
    port_reset_pin_state #(.MIN_PULSE_CYC(3)) dut (.*);
    board_model board (.*);

    // ----------
    // Tasks
    // ----------
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // Edge-by-edge wait, so a taken handshake is seen at its edge
    task automatic wt(ref logic s);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== 1'h1 && n < 50);
        if (s !== 1'h1) begin
            num_errors++;
            $display("ERROR %0t: wait timed out", $time);
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        wt(s_axi_awready);
        chk(s_axi_wready, 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        wt(s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        wt(s_axi_arready);
        s_axi_arvalid <= 1'h0;
        wt(s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic pad(input int p, input logic [7:0] oe, input logic [7:0] pu);
        #1;
        chk(port_oe[p], oe);
        chk(port_pu[p], pu);
    endtask
    // Pin reset dropped between edges: pads must react with no edge
    task automatic pulse(input int c);
        #2 reset_pin_n = 1'h0;
        #1 chk(port_oe[0], 8'h00);
        chk(port_oe[2], legacy_compat_fuse ? 8'hFF : 8'h00);
        chk(port_pu[5], jtag_enable ? 8'hB0 : 8'h00);
        repeat (c) @(posedge aclk);
        reset_pin_n <= 1'h1;
        repeat (8) @(posedge aclk);
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (2) @(posedge aclk);
        #1 chk(port_oe[2], 8'hFF);
        chk(port_oe[6], 8'h07);
        chk(port_out[6][2:0], 3'h3);
        @(posedge aclk);
        aresetn <= 1'h1;
        $display("test power_up done");
        wr(port_reset_pkg::DIR_BASE + 8'h14, 32'hFF);
        wr(port_reset_pkg::DIR_BASE + 8'h08, 32'h00);
        pad(5, 8'h00, 8'h00);
        chk(port_oe[2], 8'hFF);
        chk(port_out[6][2:0], 3'h5);
        rd_reg(port_reset_pkg::STATUS_ADDR);
        chk(rd[0], 1'h1);
        pulse(6);
        legacy_compat_fuse <= 1'h0;
        repeat (4) @(posedge aclk);
        $display("test legacy done");
        for (int p = 0; p < 7; p++) begin
            m = (p == 6) ? 8'h1F : 8'hFF;
            wr(port_reset_pkg::DIR_BASE + 8'(4 * p), 32'h0F);
            wr(port_reset_pkg::OUT_BASE + 8'(4 * p), 32'hA5);
            wr(port_reset_pkg::PUE_BASE + 8'(4 * p), 32'hFF);
            chk(rs, port_reset_pkg::RESP_OKAY);
            pad(p, 8'h0F, 8'hF0 & m);
            chk(port_out[p][3:0], 4'h5);
            repeat (3) @(posedge aclk);
            rd_reg(port_reset_pkg::PIN_BASE + 8'(4 * p));
            chk(rd & 32'(m), 32'(8'hF5 & m));
        end
        pulse(1);
        pad(0, 8'h0F, 8'hF0);
        pulse(8);
        rd_reg(port_reset_pkg::DIR_BASE);
        chk(rd, 32'h0);
        $display("test ports done");
        jtag_enable <= 1'h1;
        wr(port_reset_pkg::DIR_BASE + 8'h14, 32'h40);
        repeat (3) @(posedge aclk);
        chk(port_oe[5][6], 1'h0);
        pulse(2);
        tap_shift_out <= 1'h1;
        repeat (4) @(posedge aclk);
        chk(port_oe[5][6], 1'h1);
        chk(port_out[5][6], 1'h1);
        jtag_enable <= 1'h0;
        tap_shift_out <= 1'h0;
        wr(port_reset_pkg::DIR_BASE + 8'h14, 32'hFF);
        adc_in_use <= 8'hF0;
        repeat (4) @(posedge aclk);
        chk(port_oe[5], 8'h0F);
        $display("test test_port done");
        wr(8'h84, 32'hFF);
        chk(rs, port_reset_pkg::RESP_SLVERR);
        rd_reg(8'hA0);
        chk(rs, port_reset_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        serial_prog_entry_pin <= 1'h0;
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (6) @(posedge aclk);
        chk(serial_prog_mode, 1'h1);
        rd_reg(port_reset_pkg::STATUS_ADDR);
        chk(rd[2], 1'h1);
        $display("test prog done");
        print_verdict();
    end
endmodule
